// file: rtl/sbs_cycle_ctrl.sv
// Cycle control of a synchronous pipelined burst SRAM.
//
// Behaviour
// R1 - Deselect cycles on listed enable and strobe combinations
// R2 - Read burst begins at external address
// R3 - Controller strobe with write starts write burst
// R4 - Continue read at next burst address
// R5 - Continue write at next burst address
// R6 - Suspend burst, read current address again
// R7 - Suspend burst, write current address
// R8 - Wide decoded write from global and lanes
// R9 - Narrow decoded write from global and lanes
// R10 - Only selected byte lanes are written
// R11 - Narrow variant has two lanes with parity
// R12 - Processor strobe start is always read
// R13 - Controller writes in the following wait cycle
// R14 - Controller keeps output enable high around writes
// R15 - Outputs high impedance from power-up until read
// R16 - Sleep request is asynchronous, selects sleep
// R17 - Two cycles to enter and exit sleep
// R18 - Array contents kept through sleep
// R19 - Access pending at sleep entry is dropped
// R20 - Controller deselects before requesting sleep
// R21 - Two recovery cycles with enables inactive
// R22 - Two-bit burst counter from low address
// R23 - Outputs off on any write cycle
// R24 - Outputs off one edge after deselect
// R25 - First cycle after selection keeps outputs off
// R26 - Linear add or interleaved XOR order
// R27 - Read data one edge after address
module sbs_cycle_ctrl #(
   parameter int unsigned LANES = sbs_pkg::LANES_X36,      // Four for the wide part, two for the narrow one.
   parameter int unsigned AW    = sbs_pkg::ADDR_BITS_X36   // Word address width.
) (
   input  wire logic                          clk_i,            // Clock.
   input  wire logic                          rst_i,            // Asynchronous reset, active high.
   input  wire sbs_pkg::sbs_ctl_s             ctl_i,            // Enables, strobes and advance.
   input  wire sbs_pkg::sbs_wr_s              wr_i,             // Write controls.
   input  wire logic [AW-1:0]                 addr_i,           // External address.
   input  wire logic                          out_enable_n_i,   // Output enable, active low, pin.
   input  wire logic                          linear_order_i,   // Burst order select, pin.
   input  wire logic                          sleep_request_i,  // Sleep request, asynchronous.
   input  wire logic [LANES*sbs_pkg::LANE_BITS-1:0] dq_i,       // Data bus in, lane-major with parity.
   output logic      [LANES*sbs_pkg::LANE_BITS-1:0] dq_o,       // Data bus out, registered.
   output logic                               dq_oe_o,          // Data bus output enable, high drives.
   output logic                               sleeping_o        // Sleep mode active.
);

   localparam int unsigned DW = LANES * sbs_pkg::LANE_BITS;

   // ---------------------------------------------------------------
   // Write decode
   // ---------------------------------------------------------------
   // Decoded write is low on global write, or byte write with any lane.
   function automatic logic write_n_f(input sbs_pkg::sbs_wr_s w);
      logic any_lane;
      any_lane  = ~&w.lane_select_n[LANES-1:0];
      write_n_f = ~(~w.global_write_n | (~w.byte_write_enable_n & any_lane));   // [R8] [R9]
   endfunction

   // Lanes to update: all on global write, else the selected ones with byte write enabled, none without.
   function automatic logic [LANES-1:0] lanes_f(input sbs_pkg::sbs_wr_s w);
      lanes_f = ~w.global_write_n ? {LANES{1'b1}} :
                (w.byte_write_enable_n ? {LANES{1'b0}} : ~w.lane_select_n[LANES-1:0]);  // [R10] [R11]
   endfunction

   // ---------------------------------------------------------------
   // Sleep synchroniser and entry/exit delay
   // ---------------------------------------------------------------
   logic       sleep_s1_r;
   logic       sleep_s2_r;
   logic [1:0] sleep_cnt_r;
   logic       sleeping_r;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sleep_s1_r <= 1'b0;
         sleep_s2_r <= 1'b0;
      end else begin
         sleep_s1_r <= sleep_request_i;                      // [R16]
         sleep_s2_r <= sleep_s1_r;
      end
   end

   // The request must hold steady for the full count before the mode flips.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sleep_cnt_r <= sbs_pkg::SLEEP_CNT_RST;
         sleeping_r  <= 1'b0;
      end else if (sleep_s2_r == sleeping_r) begin
         sleep_cnt_r <= sbs_pkg::SLEEP_CNT_RST;
      end else if (sleep_cnt_r ==
                   2'((sleeping_r ? sbs_pkg::SLEEP_RECOVERY_CYCLES : sbs_pkg::SLEEP_ENTRY_CYCLES) - 1)) begin
         sleep_cnt_r <= sbs_pkg::SLEEP_CNT_RST;
         sleeping_r  <= sleep_s2_r;                          // [R17]
      end else begin
         sleep_cnt_r <= sleep_cnt_r + 2'h1;
      end
   end

   assign sleeping_o = sleeping_r;

   // ---------------------------------------------------------------
   // Cycle decode
   // ---------------------------------------------------------------
   sbs_pkg::sbs_op_e op_nxt;
   logic             all_sel;
   logic             dec_write_n;

   assign all_sel     = ~ctl_i.chip_enable_n & ctl_i.depth_select_high & ~ctl_i.depth_select_low_n;
   assign dec_write_n = write_n_f(wr_i);

   always_comb begin
      op_nxt = sbs_pkg::SBS_OP_IDLE;
      if (sleeping_r || sleep_s2_r) begin
         op_nxt = sbs_pkg::SBS_OP_IDLE;                      // [R19]
      end else if (~ctl_i.chip_enable_n & ~ctl_i.processor_addr_strobe_n) begin
         // The processor strobe only counts with the primary enable low.
         if (all_sel) begin
            op_nxt = sbs_pkg::SBS_OP_READ_EXT;               // [R2] [R12]
         end else begin
            op_nxt = sbs_pkg::SBS_OP_DESELECT;               // [R1]
         end
      end else if (~ctl_i.controller_addr_strobe_n) begin
         if (!all_sel) begin
            op_nxt = sbs_pkg::SBS_OP_DESELECT;               // [R1]
         end else if (dec_write_n) begin
            op_nxt = sbs_pkg::SBS_OP_READ_EXT;               // [R2]
         end else begin
            op_nxt = sbs_pkg::SBS_OP_WRITE_EXT;              // [R3]
         end
      end else if (~ctl_i.burst_advance_n) begin
         op_nxt = dec_write_n ? sbs_pkg::SBS_OP_READ_NEXT : sbs_pkg::SBS_OP_WRITE_NEXT;  // [R4] [R5]
      end else begin
         op_nxt = dec_write_n ? sbs_pkg::SBS_OP_READ_CUR : sbs_pkg::SBS_OP_WRITE_CUR;    // [R6] [R7] [R13]
      end
   end

   // ---------------------------------------------------------------
   // Address register and burst counter
   // ---------------------------------------------------------------
   logic [AW-1:0] addr_r;
   logic [1:0]    offs;
   logic          is_ext;
   logic          is_next;
   logic          active_r;

   assign is_ext  = (op_nxt == sbs_pkg::SBS_OP_READ_EXT) || (op_nxt == sbs_pkg::SBS_OP_WRITE_EXT);
   assign is_next = (op_nxt == sbs_pkg::SBS_OP_READ_NEXT) || (op_nxt == sbs_pkg::SBS_OP_WRITE_NEXT);

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         addr_r <= '0;
      end else if (is_ext) begin
         addr_r <= addr_i;
      end
   end

   // Burst cycles without a prior start are ignored instead of touching the array.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         active_r <= 1'b0;
      end else if (is_ext) begin
         active_r <= 1'b1;
      end else if (op_nxt == sbs_pkg::SBS_OP_DESELECT || sleeping_r || sleep_s2_r) begin
         active_r <= 1'b0;                                   // [R19]
      end
   end

   sbs_burst_counter u_cnt (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .load_i   (is_ext),
      .start_i  (addr_i[sbs_pkg::BURST_BITS-1:0]),
      .adv_i    (is_next && active_r),
      .linear_i (linear_order_i),
      .hold_i   (sleeping_r || sleep_s2_r),
      .offs_o   (offs)
   );

   // The array address is the registered base with its low bits from the counter.
   logic [AW-1:0] ram_addr;
   assign ram_addr = {addr_r[AW-1:sbs_pkg::BURST_BITS], offs};  // [R22]

   // ---------------------------------------------------------------
   // Registered operation, write data and array
   // ---------------------------------------------------------------
   sbs_pkg::sbs_op_e op_r;
   logic [LANES-1:0] lanes_r;
   logic [DW-1:0]    wd_r;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         op_r    <= sbs_pkg::SBS_OP_IDLE;
         lanes_r <= '0;
         wd_r    <= '0;
      end else begin
         op_r    <= (is_ext || active_r) ? op_nxt :
                    (op_nxt == sbs_pkg::SBS_OP_DESELECT ? op_nxt : sbs_pkg::SBS_OP_IDLE);
         lanes_r <= lanes_f(wr_i);                           // [R10]
         wd_r    <= dq_i;
      end
   end

   logic wr_cyc;
   logic rd_cyc;
   assign wr_cyc = (op_r == sbs_pkg::SBS_OP_WRITE_EXT) || (op_r == sbs_pkg::SBS_OP_WRITE_NEXT) ||
                   (op_r == sbs_pkg::SBS_OP_WRITE_CUR);
   assign rd_cyc = (op_r == sbs_pkg::SBS_OP_READ_EXT) || (op_r == sbs_pkg::SBS_OP_READ_NEXT) ||
                   (op_r == sbs_pkg::SBS_OP_READ_CUR);

   // Sleep blocks the write strobe so stored words stay as they were.
   sbs_lane_ram #(
      .AW    (AW),
      .LANES (LANES),
      .LBITS (sbs_pkg::LANE_BITS)
   ) u_ram (
      .clk_i  (clk_i),
      .we_i   (wr_cyc && !sleeping_r && !sleep_s2_r),        // [R18]
      .lane_i (lanes_r),
      .addr_i (ram_addr),
      .wd_i   (wd_r),
      .rd_o   (dq_o)                                         // [R27]
   );

   // ---------------------------------------------------------------
   // Output drive control
   // ---------------------------------------------------------------
   logic rd_valid_r;
   logic desel_r;

   // A read cycle registered now presents its data after the next edge.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rd_valid_r <= 1'b0;                                 // [R15]
         desel_r    <= 1'b1;
      end else begin
         rd_valid_r <= rd_cyc && !desel_r;                   // [R25] [R27]
         desel_r    <= (op_r == sbs_pkg::SBS_OP_DESELECT) || (op_r == sbs_pkg::SBS_OP_IDLE && !active_r);  // [R24]
      end
   end

   // Output enable is a pin sampled asynchronously; writes always win.
   assign dq_oe_o = rd_valid_r && !out_enable_n_i && !wr_cyc && !sleeping_r;  // [R23] [R14]

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   AST_WRITE_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_cyc |-> !dq_oe_o)                                  // [R23]
      else $error("bus driven during write cycle");

   AST_DESEL_DEC: assert property (@(posedge clk_i) disable iff (rst_i)
      (!sleeping_r && !sleep_s2_r && ctl_i.chip_enable_n && !ctl_i.controller_addr_strobe_n)
      |-> op_nxt == sbs_pkg::SBS_OP_DESELECT)                // [R1]
      else $error("deselect not decoded");

   AST_PSTROBE_READ: assert property (@(posedge clk_i) disable iff (rst_i)
      (!sleeping_r && !sleep_s2_r && all_sel && !ctl_i.processor_addr_strobe_n)
      |=> op_r == sbs_pkg::SBS_OP_READ_EXT)                 // [R12]
      else $error("processor strobe did not start read");

   AST_CSTROBE_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
      (!sleeping_r && !sleep_s2_r && all_sel && ctl_i.processor_addr_strobe_n &&
       !ctl_i.controller_addr_strobe_n && !dec_write_n) |=> op_r == sbs_pkg::SBS_OP_WRITE_EXT)  // [R3]
      else $error("controller strobe write not started");

   AST_READ_PIPE: assert property (@(posedge clk_i) disable iff (rst_i)
      (rd_cyc && !desel_r) |=> rd_valid_r)                   // [R27]
      else $error("read data not valid one edge later");

   AST_DESEL_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
      (op_r == sbs_pkg::SBS_OP_DESELECT) |=> ##1 !rd_valid_r) // [R24]
      else $error("outputs still on after deselect");

   AST_SLEEP_ENTRY: assert property (@(posedge clk_i) disable iff (rst_i)
      ($rose(sleep_s2_r) && !sleeping_r) ##1 sleep_s2_r |=> sleeping_r)  // [R17]
      else $error("sleep not entered in two cycles");

   AST_SLEEP_NOWRITE: assert property (@(posedge clk_i) disable iff (rst_i)
      sleeping_r |-> !wr_cyc)                                // [R18]
      else $error("array written during sleep");

   AST_WDEC: assert property (@(posedge clk_i) disable iff (rst_i)
      !wr_i.global_write_n |-> !dec_write_n)                 // [R8] [R9]
      else $error("global write not decoded");

endmodule

// file: rtl/sbs_pkg.sv
// Package with constants, types and pin groups for the burst SRAM cycle control.
package sbs_pkg;

   // ---------------------------------------------------------------
   // Geometry
   // ---------------------------------------------------------------
   localparam int unsigned LANES_X36      = 4;
   localparam int unsigned LANES_X18      = 2;
   localparam int unsigned LANE_BITS      = 9;   // Eight data bits plus one parity bit.
   localparam int unsigned BURST_BITS     = 2;
   localparam int unsigned ADDR_BITS_X36  = 18;
   localparam int unsigned LANE0_DATA_LSB = 0;
   localparam int unsigned LANE0_DATA_MSB = 7;
   localparam int unsigned LANE1_DATA_LSB = 8;
   localparam int unsigned LANE1_DATA_MSB = 15;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS        = 10;
   localparam int unsigned SLEEP_ENTRY_CYCLES   = 2;
   localparam int unsigned SLEEP_ENTRY_TIME_NS  = SLEEP_ENTRY_CYCLES * CLK_PERIOD_NS;
   localparam int unsigned SLEEP_RECOVERY_TIME_NS = 2 * CLK_PERIOD_NS;
   localparam int unsigned SLEEP_RECOVERY_CYCLES =
      (SLEEP_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [1:0]  SLEEP_CNT_RST = 2'h0;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      SBS_OP_IDLE,
      SBS_OP_DESELECT,
      SBS_OP_READ_EXT,
      SBS_OP_WRITE_EXT,
      SBS_OP_READ_NEXT,
      SBS_OP_WRITE_NEXT,
      SBS_OP_READ_CUR,
      SBS_OP_WRITE_CUR
   } sbs_op_e;

   typedef struct packed {
      logic chip_enable_n;
      logic depth_select_high;
      logic depth_select_low_n;
      logic processor_addr_strobe_n;
      logic controller_addr_strobe_n;
      logic burst_advance_n;
   } sbs_ctl_s;

   typedef struct packed {
      logic       global_write_n;
      logic       byte_write_enable_n;
      logic [3:0] lane_select_n;   // Lane a in bit 0 through lane d in bit 3.
   } sbs_wr_s;

endpackage

// file: rtl/sbs_burst_counter.sv
// Two-bit wraparound burst counter with linear or interleaved order.
module sbs_burst_counter (
   input  wire logic       clk_i,     // Clock.
   input  wire logic       rst_i,     // Asynchronous reset, active high.
   input  wire logic       load_i,    // Load a new start offset.
   input  wire logic [1:0] start_i,   // Start offset from the low address bits.
   input  wire logic       adv_i,     // Advance one step.
   input  wire logic       linear_i,  // High for linear order.
   input  wire logic       hold_i,    // Sleep freezes the counter.
   output logic      [1:0] offs_o     // Current burst offset.
);

   logic [1:0] start_r;
   logic [1:0] step_r;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         start_r <= 2'h0;
         step_r  <= 2'h0;
      end else if (hold_i) begin
         step_r  <= step_r;
      end else if (load_i) begin
         start_r <= start_i;                                 // [R22]
         step_r  <= 2'h0;
      end else if (adv_i) begin
         step_r  <= step_r + 2'h1;                           // [R26]
      end
   end

   // Linear adds the step modulo four; interleaved XORs it with the start.
   assign offs_o = linear_i ? start_r + step_r : start_r ^ step_r;  // [R26]

   AST_WRAP: assert property (@(posedge clk_i) disable iff (rst_i)
      (adv_i && !load_i && !hold_i) |=> (step_r == $past(step_r) + 2'h1))  // [R22]
      else $error("burst counter did not advance");

endmodule

// file: rtl/sbs_lane_ram.sv
// Byte-lane storage array with registered read data.
module sbs_lane_ram #(
   parameter int unsigned AW    = 18,
   parameter int unsigned LANES = 4,
   parameter int unsigned LBITS = 9
) (
   input  wire logic                   clk_i,   // Clock.
   input  wire logic                   we_i,    // Write strobe.
   input  wire logic [LANES-1:0]       lane_i,  // Lanes to update, active high.
   input  wire logic [AW-1:0]          addr_i,  // Word address.
   input  wire logic [LANES*LBITS-1:0] wd_i,    // Write data.
   output logic      [LANES*LBITS-1:0] rd_o     // Registered read data.
);

   // The array has no reset so contents survive anything but power loss.
   // Each lane owns its own array, so every array has a single writing process.
   for (genvar g = 0; g < LANES; g++) begin : g_lane
      logic [LBITS-1:0] mem [0:(1<<AW)-1];

      always_ff @(posedge clk_i) begin
         if (we_i && lane_i[g]) begin
            mem[addr_i] <= wd_i[g*LBITS +: LBITS];
         end
         rd_o[g*LBITS +: LBITS] <= mem[addr_i];
      end
   end

endmodule

// file: test/sbs_host_model.sv
// Controller-side bus model that drives the burst SRAM pins.
module sbs_host_model (
   input  wire logic         clk_i,   // Clock.
   output sbs_pkg::sbs_ctl_s ctl_o,   // Selects and strobes.
   output sbs_pkg::sbs_wr_s  wr_o,    // Write controls.
   output logic [17:0]       addr_o,  // Address.
   output logic [35:0]       dq_o,    // Data to the device.
   output logic              oe_n_o,  // Output enable, low.
   output logic              sleep_o  // Sleep request.
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam sbs_pkg::sbs_wr_s NOWR = '{1'b1, 1'b1, 4'hf};

   initial begin
      ctl_o   = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
      wr_o    = NOWR;
      addr_o  = '0;
      dq_o    = '0;
      oe_n_o  = 1'b1;
      sleep_o = 1'b0;
   end

   // Sel 0 selects the part, 1 to 3 drop one enable, 4 drops them all.
   task automatic put(input int sel, input logic [2:0] s, input sbs_pkg::sbs_wr_s w,
                      input logic [17:0] a, input logic [35:0] d, input logic oe, input logic rude);
      logic wl;
      wl = !w.global_write_n || (!w.byte_write_enable_n && w.lane_select_n != 4'hf);
      @(posedge clk_i);
      ctl_o  <= '{sel == 1 || sel == 4, sel != 2 && sel != 4, sel == 3 || sel == 4, s[2], s[1], s[0]};
      wr_o   <= w;
      addr_o <= a;
      dq_o   <= wl ? d : ~dq_o;       // An idle bus never repeats old data.
      oe_n_o <= oe | (wl & !rude);
   endtask

   // Sleep is only requested from a deselected, quiet bus.
   task automatic nap(input int hold);
      put(1, 3'b101, NOWR, '0, '0, 1'b1, 1'b0);
      put(4, 3'b111, NOWR, '0, '0, 1'b1, 1'b0);
      sleep_o <= 1'b1;
      repeat (hold) @(posedge clk_i);
      sleep_o <= 1'b0;
      repeat (3) put(4, 3'b111, NOWR, '0, '0, 1'b1, 1'b0);
   endtask
endmodule

// file: test/tb.sv
// Self-checking bench: truth-table model of the burst SRAM against the cycle control.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int W  = 36;
   localparam int AW = 18;
   localparam logic [2:0] SC = 3'b101, SP = 3'b011, NX = 3'b110, HD = 3'b111;
   localparam sbs_pkg::sbs_wr_s NOWR = '{1'b1, 1'b1, 4'hf};
   localparam sbs_pkg::sbs_wr_s GWR  = '{1'b0, 1'b1, 4'hf};

   logic              clk_i;
   logic              rst_i;
   logic              lin;
   sbs_pkg::sbs_ctl_s ctl;
   sbs_pkg::sbs_wr_s  wr;
   logic [AW-1:0]     addr;
   logic [W-1:0]      dq_w;
   logic [W-1:0]      dq_r;
   logic              oe_n;
   logic              sleep_req;
   logic              dq_oe;
   logic              sleeping;
   int                bad_count;
   int                total_checks;
   int                seed;

   sbs_host_model host (
      .clk_i   (clk_i),
      .ctl_o   (ctl),
      .wr_o    (wr),
      .addr_o  (addr),
      .dq_o    (dq_w),
      .oe_n_o  (oe_n),
      .sleep_o (sleep_req)
   );

   sbs_cycle_ctrl #(.LANES(4), .AW(AW)) DUT (
      .clk_i           (clk_i),
      .rst_i           (rst_i),
      .ctl_i           (ctl),
      .wr_i            (wr),
      .addr_i          (addr),
      .out_enable_n_i  (oe_n),
      .linear_order_i  (lin),
      .sleep_request_i (sleep_req),
      .dq_i            (dq_w),
      .dq_o            (dq_r),
      .dq_oe_o         (dq_oe),
      .sleeping_o      (sleeping)
   );

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   task automatic chk_bit(logic e, logic g);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %0t flag %b, want %b", $time, g, e);
      end
   endtask

   task automatic chk_dat(logic [W-1:0] e, logic [W-1:0] g);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %0t data %h, want %h", $time, g, e);
      end
   endtask

   // ---------------------------------------------------------------
   // Reference model
   // ---------------------------------------------------------------
   logic [W-1:0]  mem [int];
   logic          act;
   logic          dsl;
   logic [AW-1:0] base;
   logic [1:0]    step;
   logic          p_rd [3];
   logic          p_fst [3];
   logic          p_wr [3];
   logic [W-1:0]  p_dat [3];

   always @(posedge clk_i) begin : model
      logic          ce;
      logic          wl;
      logic          rd;
      logic          wt;
      logic          on;
      logic [AW-1:0] a;
      logic [W-1:0]  m;
      ce = !ctl.chip_enable_n && ctl.depth_select_high && !ctl.depth_select_low_n;
      wl = !wr.global_write_n || (!wr.byte_write_enable_n && wr.lane_select_n != 4'hf);
      rd = 1'b0;
      wt = 1'b0;
      if (rst_i) begin
         act = 1'b0;
         dsl = 1'b1;
      end else if ((!ctl.chip_enable_n && !ctl.processor_addr_strobe_n) || !ctl.controller_addr_strobe_n) begin
         act  = ce;
         dsl  = dsl | !ce;
         base = addr;
         step = 2'h0;
         wt   = ce && ctl.processor_addr_strobe_n && wl;
         rd   = ce && !wt;
      end else if (act) begin
         step = step + {1'b0, !ctl.burst_advance_n};
         wt   = wl;
         rd   = !wl;
      end
      a = {base[AW-1:2], lin ? base[1:0] + step : base[1:0] ^ step};
      m = mem.exists(int'(a)) ? mem[int'(a)] : 'x;
      if (wt) begin
         for (int g = 0; g < 4; g++)
            if (!wr.global_write_n || !wr.lane_select_n[g]) m[g*9 +: 9] = dq_w[g*9 +: 9];
         mem[int'(a)] = m;
      end
      for (int k = 2; k > 0; k--) begin
         p_rd[k]  = p_rd[k-1];
         p_fst[k] = p_fst[k-1];
         p_wr[k]  = p_wr[k-1];
         p_dat[k] = p_dat[k-1];
      end
      p_rd[0]  = rd;
      p_fst[0] = dsl;
      p_wr[0]  = wt;
      p_dat[0] = m;
      if (rd || wt) dsl = 1'b0;
      #1;
      if (!rst_i) begin
         // Read data stands on the bus one edge after the read is decoded.
         on = p_rd[1] && !p_fst[1] && !p_wr[0] && !oe_n;
         chk_bit(on, dq_oe);
         if (on && !$isunknown(p_dat[1])) chk_dat(p_dat[1], dq_r);
      end
   end

   logic last_req = 1'b0;
   logic last_slp = 1'b0;
   int   lag = 0;
   always @(posedge clk_i) begin
      #1;
      lag++;
      if (sleep_req !== last_req) begin
         last_req = sleep_req;
         lag = 0;
      end
      if (lag == 7) chk_bit(last_req, sleeping);
      if (sleeping !== last_slp) begin
         last_slp = sleeping;
         chk_bit(1'b1, 1'(lag >= 2 && lag <= 6));
      end
   end

   // ---------------------------------------------------------------
   // Stimulus
   // ---------------------------------------------------------------
   task automatic op(int sel, logic [2:0] s, sbs_pkg::sbs_wr_s w, int a, logic o);
      host.put(sel, s, w, AW'(a), W'({$random(seed), $random(seed)}), o, 1'b0);
   endtask

   task automatic readback();
      for (int g = 0; g < 4; g++) begin
         lin <= g[0];
         op(0, SC, NOWR, 5 * g, 0);
         op(0, NX, NOWR, 0, 0);
         op(0, HD, NOWR, 0, 0);
         op(0, NX, NOWR, 0, 0);
         op(0, NX, NOWR, 0, 0);
      end
      repeat (2) op(0, HD, NOWR, 0, 1);
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial begin
      logic [31:0] r;
      seed = 60103;
      bad_count = 0;
      total_checks = 0;
      rst_i = 1'b1;
      lin = 1'b1;
      repeat (16) @(posedge clk_i);
      chk_bit(1'b0, dq_oe);
      rst_i <= 1'b0;
      for (int i = 0; i < 16; i++) op(0, SC, GWR, i, 1);
      readback();
      // Lane masks walk all sixteen values; mask zero makes the start a read.
      for (int m = 0; m < 16; m++) begin
         if (m % 4 == 0) lin <= m[2];
         op(0, (m % 4 == 0) ? SC : NX, '{1'b1, 1'b0, 4'(~m)}, 5 * (m / 4), 1);
      end
      readback();
      // The bus is idled before each deselect so the last read has drained.
      for (int sel = 1; sel < 4; sel++)
         for (int p = 0; p < 2; p++) begin
            repeat (2) op(0, HD, NOWR, 0, 1);
            op(sel, p ? SC : SP, NOWR, 0, 0);
            op(0, NX, NOWR, 0, 0);
            op(0, SC, NOWR, 4 * sel + p, 0);
            op(0, NX, NOWR, 0, 0);
            op(0, NX, NOWR, 0, 0);
         end
      repeat (2) op(0, HD, NOWR, 0, 1);
      op(2, SC, NOWR, 0, 0);
      op(0, SP, GWR, 6, 1);
      op(0, HD, GWR, 0, 1);
      op(0, NX, NOWR, 0, 0);
      repeat (3) op(0, HD, NOWR, 0, 0);
      op(0, SC, NOWR, 9, 0);
      op(0, NX, NOWR, 0, 0);
      host.put(0, SC, GWR, 18'h3, W'({$random(seed), $random(seed)}), 1'b0, 1'b1);
      op(0, NX, NOWR, 0, 0);
      repeat (2) op(0, HD, NOWR, 0, 1);
      host.nap(8);
      readback();
      for (int i = 0; i < 400; i++) begin
         r = $random(seed);
         op(0, r[2:0], '{r[3] | r[4], r[5], r[9:6]}, int'(r[13:10]), r[14]);
      end
      readback();
      conclude();
   end

   initial begin
      #200000;
      bad_count++;
      conclude();
   end
endmodule
